// ===== rtl/sync_serial_port.sv
// Synchronous master/slave serial port with AXI4-Lite register access
//
// How it works
// RL1 - Clock-source bit 7 selects clock master
// RL2 - Half duplex: transmit and receive exclude
// RL3 - Sync-mode bit 4 selects synchronous operation
// RL4 - Port enable turns pins into clock/data
// RL5 - Master drives generated shift clock out
// RL6 - Shift register reloads only after last bit
// RL7 - Buffer transfer empties buffer, sets flag
// RL8 - Empty flag clears only on buffer write
// RL9 - Transmit request needs transmit interrupt enable
// RL10 - Read-only shift-empty bit, no interrupt
// RL11 - Ninth transmit bit sent after data
// RL12 - Buffer write with enable starts transmission
// RL13 - Software programs divisor before enabling master
// RL14 - Single or continuous bit enables reception
// RL15 - Receive samples data on falling edge
// RL16 - Single receive takes one word, stops
// RL17 - Continuous receive runs until bit cleared
// RL18 - Both receive bits set means continuous
// RL19 - Receive-complete flag; request needs enable
// RL20 - Status holds ninth bit, errors; clear resets
// RL21 - Software clears both receive bits first
// RL22 - Clock-source clear makes slave, no clock
// RL23 - Least significant bit first, ninth last
// RL24 - Transmit data changes on rising edge
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module sync_serial_port
	import sync_serial_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	sync_serial_if.device          link,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   irqHigh,
	output logic                   irqLow
);
	logic [7:0] txCtlReg, rxCtlReg, txBufReg, baudDivReg, pieReg, iprReg, rxBufReg, baudCntReg;
	logic       txFullReg, txActiveReg, dtOutReg, ckOutReg, rxFlagReg, overrunReg, rx9Reg;
	logic       ckSync1Reg, ckSync2Reg, ckPrevReg, dtSync1Reg, dtSync2Reg, dtPrevReg;
	logic [8:0] txShiftReg, rsrReg;
	logic [3:0] bitCntReg, rxCntReg;
	logic       bvalidReg, rvalidReg;
	logic [1:0] brespReg, rrespReg;
	logic [31:0] rdataReg;

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic wrGo, wrLane, rdGo, wrMapped, rdMapped;
	logic wrTxCtl, wrRxCtl, wrTxBuf, wrBaud, wrPie, wrIpr, rdRxBuf;
	logic [7:0] wByte, txCtlView, rxCtlView, flagView, rdByte;

	assign wrGo     = awvalid & wvalid & ~bvalidReg;
	assign awready  = wrGo;
	assign wready   = wrGo;
	assign wrLane   = wrGo & wstrb[0];
	assign wByte    = wdata[7:0];
	assign wrMapped = (awaddr[1:0] == 2'h0) & ~awaddr[5];
	assign wrTxCtl  = wrLane & (awaddr == OFF_TX_STATUS_CONTROL);
	assign wrRxCtl  = wrLane & (awaddr == OFF_RX_STATUS_CONTROL);
	assign wrTxBuf  = wrLane & (awaddr == OFF_TRANSMIT_BUFFER);
	assign wrBaud   = wrLane & (awaddr == OFF_BAUD_DIVISOR);
	assign wrPie    = wrLane & (awaddr == OFF_PERIPHERAL_ENABLES);
	assign wrIpr    = wrLane & (awaddr == OFF_PERIPHERAL_PRIO);
	assign rdGo     = arvalid & ~rvalidReg;
	assign arready  = rdGo;
	assign rdMapped = (araddr[1:0] == 2'h0) & ~araddr[5];
	assign rdRxBuf  = rdGo & (araddr == OFF_RECEIVE_BUFFER);

	// Shift-empty and error bits are status, not storage
	assign txCtlView = {txCtlReg[7:2], ~txActiveReg, txCtlReg[0]};  // RL10
	assign rxCtlView = {rxCtlReg[7:3], 1'b0, overrunReg, rx9Reg};  // RL20
	assign flagView  = {2'h0, rxFlagReg, ~txFullReg, 4'h0};  // RL8
	assign rdByte    = (araddr == OFF_TX_STATUS_CONTROL)  ? txCtlView :
	                   (araddr == OFF_RX_STATUS_CONTROL)  ? rxCtlView :
	                   (araddr == OFF_TRANSMIT_BUFFER)    ? txBufReg :
	                   (araddr == OFF_RECEIVE_BUFFER)     ? rxBufReg :
	                   (araddr == OFF_BAUD_DIVISOR)       ? baudDivReg :
	                   (araddr == OFF_PERIPHERAL_FLAGS)   ? flagView :
	                   (araddr == OFF_PERIPHERAL_ENABLES) ? pieReg :
	                   (araddr == OFF_PERIPHERAL_PRIO)    ? iprReg : 8'h00;

	assign bvalid = bvalidReg;
	assign bresp  = brespReg;
	assign rvalid = rvalidReg;
	assign rresp  = rrespReg;
	assign rdata  = rdataReg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bvalidReg <= 1'b0;
			brespReg  <= RESP_OKAY;
			rvalidReg <= 1'b0;
			rrespReg  <= RESP_OKAY;
			rdataReg  <= 32'h0000_0000;
		end else begin
			if (wrGo) begin
				bvalidReg <= 1'b1;
				brespReg  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalidReg <= 1'b0;
			end
			if (rdGo) begin
				rvalidReg <= 1'b1;
				rrespReg  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
				rdataReg  <= {24'h000000, rdByte};
			end else if (rready) begin
				rvalidReg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode and shift clock
	logic portOn, isMaster, rxEnable, rxCont, rxRun, clkRun, baudHit, riseEv, fallEv;
	logic txLast, txLoad, rxLast, rxDone, rxLost;
	logic [3:0] txLastIdx, rxLastIdx;
	logic [8:0] rxShifted;

	assign portOn   = rxCtlReg[RXS_PORT_ENABLE] & txCtlReg[TXS_SYNC_MODE];  // RL3 RL4
	assign isMaster = txCtlReg[TXS_CLOCK_SOURCE];  // RL1 RL22
	assign rxCont   = rxCtlReg[RXS_CONTINUOUS];
	assign rxEnable = rxCtlReg[RXS_SINGLE] | rxCont;  // RL14
	assign rxRun    = portOn & rxEnable & ~txActiveReg;  // RL2
	assign clkRun   = portOn & isMaster & (txActiveReg | rxRun);  // RL5
	assign baudHit  = clkRun & (baudCntReg == baudDivReg);  // RL13
	assign riseEv   = isMaster ? (baudHit & ~ckOutReg) : (portOn & ckSync2Reg & ~ckPrevReg);
	assign fallEv   = isMaster ? (baudHit & ckOutReg) : (portOn & ~ckSync2Reg & ckPrevReg);

	assign link.devCkOut = ckOutReg;
	assign link.devCkOe  = portOn & isMaster;  // RL5 RL22
	assign link.devDtOut = dtOutReg;
	assign link.devDtOe  = portOn & txActiveReg;  // RL4

	assign irqHigh = (rxFlagReg & pieReg[PF_RX_COMPLETE] & iprReg[PF_RX_COMPLETE]) |
	                 (~txFullReg & pieReg[PF_TX_EMPTY] & iprReg[PF_TX_EMPTY]);  // RL9 RL19
	assign irqLow  = (rxFlagReg & pieReg[PF_RX_COMPLETE] & ~iprReg[PF_RX_COMPLETE]) |
	                 (~txFullReg & pieReg[PF_TX_EMPTY] & ~iprReg[PF_TX_EMPTY]);  // RL9 RL19

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{ckSync1Reg, ckSync2Reg, ckPrevReg} <= 3'h0;
			{dtSync1Reg, dtSync2Reg, dtPrevReg} <= 3'h7;
		end else begin
			ckSync1Reg <= link.shiftClockLine;
			ckSync2Reg <= ckSync1Reg;
			ckPrevReg  <= ckSync2Reg;
			dtSync1Reg <= link.shiftDataLine;
			dtSync2Reg <= dtSync1Reg;
			dtPrevReg  <= dtSync2Reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			baudCntReg <= 8'h00;
			ckOutReg   <= 1'b0;
		end else if (!clkRun) begin
			baudCntReg <= 8'h00;
			ckOutReg   <= 1'b0;
		end else if (baudHit) begin
			baudCntReg <= 8'h00;
			ckOutReg   <= ~ckOutReg;  // RL5
		end else begin
			baudCntReg <= baudCntReg + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txCtlReg   <= REG_RESET;
			rxCtlReg   <= REG_RESET;
			baudDivReg <= REG_RESET;
			pieReg     <= REG_RESET;
			iprReg     <= REG_RESET;
		end else begin
			if (wrTxCtl) txCtlReg <= wByte & TXS_WRITE_MASK;
			if (wrBaud) baudDivReg <= wByte;
			if (wrPie) pieReg <= wByte & PE_WRITE_MASK;
			if (wrIpr) iprReg <= wByte & PE_WRITE_MASK;
			if (wrRxCtl) begin
				rxCtlReg <= wByte & RXS_WRITE_MASK;
			end else if (rxDone && !rxCont) begin
				rxCtlReg[RXS_SINGLE] <= 1'b0;  // RL16 RL18
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit path
	assign txLastIdx = txCtlReg[TXS_NINE_BIT] ? LAST_BIT_9 : LAST_BIT_8;
	assign txLast    = bitCntReg == txLastIdx;
	assign txLoad    = portOn & txCtlReg[TXS_TX_ENABLE] & txFullReg & ~rxEnable &
	                   (~txActiveReg | (fallEv & txLast));  // RL2 RL6 RL12

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txBufReg  <= REG_RESET;
			txFullReg <= 1'b0;
		end else if (wrTxBuf) begin
			txBufReg  <= wByte;
			txFullReg <= 1'b1;  // RL8
		end else if (txLoad) begin
			txFullReg <= 1'b0;  // RL7
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txShiftReg  <= 9'h000;
			txActiveReg <= 1'b0;
			bitCntReg   <= 4'h0;
			dtOutReg    <= 1'b1;
		end else if (!portOn) begin
			txActiveReg <= 1'b0;
		end else if (txLoad) begin
			txShiftReg  <= {txCtlReg[TXS_NINTH_TX], txBufReg};  // RL7 RL11
			txActiveReg <= 1'b1;
			bitCntReg   <= 4'h0;
		end else if (txActiveReg) begin
			if (riseEv) dtOutReg <= txShiftReg[0];  // RL23 RL24
			if (fallEv) begin
				txShiftReg  <= {1'b0, txShiftReg[8:1]};
				bitCntReg   <= bitCntReg + 4'h1;
				txActiveReg <= ~txLast;  // RL6
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive path
	assign rxLastIdx = rxCtlReg[RXS_NINE_BIT] ? LAST_BIT_9 : LAST_BIT_8;
	assign rxLast    = rxCntReg == rxLastIdx;
	assign rxDone    = fallEv & rxRun & rxLast;
	assign rxLost    = rxDone & rxFlagReg & ~rdRxBuf;
	assign rxShifted = {isMaster ? dtSync2Reg : dtPrevReg, rsrReg[8:1]};  // Slave: data from before the seen fall

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rsrReg   <= 9'h000;
			rxCntReg <= 4'h0;
		end else if (!rxRun) begin
			rxCntReg <= 4'h0;
		end else if (fallEv) begin
			rsrReg   <= rxShifted;  // RL15 RL23
			rxCntReg <= rxLast ? 4'h0 : rxCntReg + 4'h1;  // RL17
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxBufReg   <= REG_RESET;
			rx9Reg     <= 1'b0;
			rxFlagReg  <= 1'b0;
			overrunReg <= 1'b0;
		end else begin
			if (rdRxBuf) rxFlagReg <= 1'b0;
			if (wrRxCtl && !wByte[RXS_CONTINUOUS]) overrunReg <= 1'b0;  // RL20
			if (rxLost) begin
				overrunReg <= 1'b1;
			end else if (rxDone) begin
				rxBufReg  <= rxCtlReg[RXS_NINE_BIT] ? rxShifted[7:0] : rxShifted[8:1];  // RL20
				rx9Reg    <= rxCtlReg[RXS_NINE_BIT] & rxShifted[8];
				rxFlagReg <= 1'b1;  // RL19
			end
		end
	end

endmodule : sync_serial_port

// ===== common/sync_serial_pkg.sv
// Shared constants for the synchronous serial port and its link peer
package sync_serial_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses of aligned 32-bit words
	localparam int          ADDR_W                 = 6;
	localparam logic [5:0]  OFF_TX_STATUS_CONTROL  = 6'h00;
	localparam logic [5:0]  OFF_RX_STATUS_CONTROL  = 6'h04;
	localparam logic [5:0]  OFF_TRANSMIT_BUFFER    = 6'h08;
	localparam logic [5:0]  OFF_RECEIVE_BUFFER     = 6'h0C;
	localparam logic [5:0]  OFF_BAUD_DIVISOR       = 6'h10;
	localparam logic [5:0]  OFF_PERIPHERAL_FLAGS   = 6'h14;
	localparam logic [5:0]  OFF_PERIPHERAL_ENABLES = 6'h18;
	localparam logic [5:0]  OFF_PERIPHERAL_PRIO    = 6'h1C;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int TXS_CLOCK_SOURCE = 7;
	localparam int TXS_NINE_BIT     = 6;
	localparam int TXS_TX_ENABLE    = 5;
	localparam int TXS_SYNC_MODE    = 4;
	localparam int TXS_SHIFT_EMPTY  = 1;
	localparam int TXS_NINTH_TX     = 0;
	localparam int RXS_PORT_ENABLE  = 7;
	localparam int RXS_NINE_BIT     = 6;
	localparam int RXS_SINGLE       = 5;
	localparam int RXS_CONTINUOUS   = 4;
	localparam int RXS_FRAMING      = 2;
	localparam int RXS_OVERRUN      = 1;
	localparam int RXS_NINTH_RX     = 0;
	localparam int PF_RX_COMPLETE   = 5;
	localparam int PF_TX_EMPTY      = 4;

	////////////////////////////////////////////////////////////////////////
	// Writable masks and reset values
	localparam logic [7:0] TXS_WRITE_MASK = 8'hF5;
	localparam logic [7:0] RXS_WRITE_MASK = 8'hF8;
	localparam logic [7:0] PE_WRITE_MASK  = 8'h30;
	localparam logic [7:0] REG_RESET      = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Word lengths, bus answers, link timing
	localparam logic [3:0] LAST_BIT_8     = 4'h7;
	localparam logic [3:0] LAST_BIT_9     = 4'h8;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	localparam int         MCLK_PERIOD_NS = 40;
	localparam int         LINK_PERIOD_NS = 320;
	localparam logic [7:0] PEER_HALF_CYCLES = 8'(LINK_PERIOD_NS / (2 * MCLK_PERIOD_NS));

endpackage : sync_serial_pkg

// ===== common/sync_serial_if.sv
// Shared shift clock and data lines between the serial port and its peer
`timescale 1ns/100ps
interface sync_serial_if;
	logic devCkOut;
	logic devCkOe;
	logic devDtOut;
	logic devDtOe;
	logic peerCkOut;
	logic peerCkOe;
	logic peerDtOut;
	logic peerDtOe;
	logic shiftClockLine;
	logic shiftDataLine;

	// Undriven clock idles low through a pull-down, so handing it over makes no false edge
	// Undriven data idles high through a pull-up
	assign shiftClockLine = devCkOe ? devCkOut : (peerCkOe ? peerCkOut : 1'b0);
	assign shiftDataLine  = devDtOe ? devDtOut : (peerDtOe ? peerDtOut : 1'b1);

	modport device (output devCkOut, devCkOe, devDtOut, devDtOe, input shiftClockLine, shiftDataLine);
	modport peer (output peerCkOut, peerCkOe, peerDtOut, peerDtOe, input shiftClockLine, shiftDataLine);
endinterface : sync_serial_if

// ===== rtl/sync_serial_peer.sv
// External synchronous peer: clock slave or master, shifts 8 or 9 bit words LSB first
`timescale 1ns/100ps
module sync_serial_peer
	import sync_serial_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	sync_serial_if.peer     link,
	input  wire logic       clockMaster,
	input  wire logic       runClock,
	input  wire logic       nineBit,
	input  wire logic [8:0] txData,
	input  wire logic       txValid,
	output logic            txReady,
	output logic [8:0]      rxData,
	output logic            rxValid
);
	logic       ckSync1Reg, ckSync2Reg, ckPrevReg, dtSync1Reg, dtSync2Reg, dtPrevReg;
	logic       ckOutReg, sendingReg, dtOutReg, rxValidReg;
	logic [7:0] divCntReg;
	logic [3:0] bitCntReg, rxCntReg;
	logic [8:0] shiftReg, rsrReg, rxDataReg;
	logic       clkRun, divHit, riseEv, fallEv, lastTx, lastRx, rxDone;
	logic [3:0] lastIdx;
	logic [8:0] shifted;

	////////////////////////////////////////////////////////////////////////
	// Edge sources
	assign clkRun  = clockMaster & (runClock | sendingReg);
	assign divHit  = clkRun & (divCntReg == PEER_HALF_CYCLES - 8'h01);
	assign riseEv  = clockMaster ? (divHit & ~ckOutReg) : (ckSync2Reg & ~ckPrevReg);
	assign fallEv  = clockMaster ? (divHit & ckOutReg) : (~ckSync2Reg & ckPrevReg);
	assign lastIdx = nineBit ? LAST_BIT_9 : LAST_BIT_8;
	assign lastTx  = bitCntReg == lastIdx;
	assign lastRx  = rxCntReg == lastIdx;
	assign rxDone  = fallEv & ~sendingReg & lastRx;
	assign shifted = {clockMaster ? dtSync2Reg : dtPrevReg, rsrReg[8:1]};  // Slave: data from before the seen fall
	assign txReady = ~sendingReg;

	assign link.peerCkOut = ckOutReg;
	assign link.peerCkOe  = clockMaster;
	assign link.peerDtOut = dtOutReg;
	assign link.peerDtOe  = sendingReg;
	assign rxData         = rxDataReg;
	assign rxValid        = rxValidReg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{ckSync1Reg, ckSync2Reg, ckPrevReg} <= 3'h0;
			{dtSync1Reg, dtSync2Reg, dtPrevReg} <= 3'h7;
		end else begin
			ckSync1Reg <= link.shiftClockLine;
			ckSync2Reg <= ckSync1Reg;
			ckPrevReg  <= ckSync2Reg;
			dtSync1Reg <= link.shiftDataLine;
			dtSync2Reg <= dtSync1Reg;
			dtPrevReg  <= dtSync2Reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			divCntReg <= 8'h00;
			ckOutReg  <= 1'b0;
		end else if (!clkRun) begin
			divCntReg <= 8'h00;
			ckOutReg  <= 1'b0;
		end else if (divHit) begin
			divCntReg <= 8'h00;
			ckOutReg  <= ~ckOutReg;
		end else begin
			divCntReg <= divCntReg + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit: drive on rising edge, advance on falling edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sendingReg <= 1'b0;
			shiftReg   <= 9'h000;
			bitCntReg  <= 4'h0;
			dtOutReg   <= 1'b1;
		end else if (txValid && !sendingReg) begin
			sendingReg <= 1'b1;
			shiftReg   <= txData;
			bitCntReg  <= 4'h0;
		end else if (sendingReg) begin
			if (riseEv) begin
				dtOutReg <= shiftReg[0];
			end
			if (fallEv) begin
				shiftReg  <= {1'b0, shiftReg[8:1]};
				bitCntReg <= bitCntReg + 4'h1;
				sendingReg <= ~lastTx;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive: sample on falling edge while not sending
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rsrReg     <= 9'h000;
			rxCntReg   <= 4'h0;
			rxDataReg  <= 9'h000;
			rxValidReg <= 1'b0;
		end else begin
			rxValidReg <= rxDone;
			if (sendingReg) begin
				rxCntReg <= 4'h0;
			end else if (fallEv) begin
				rsrReg   <= shifted;
				rxCntReg <= lastRx ? 4'h0 : rxCntReg + 4'h1;
			end
			if (rxDone) begin
				rxDataReg <= nineBit ? shifted : {1'b0, shifted[8:1]};
			end
		end
	end

endmodule : sync_serial_peer

// ===== sim/sync_serial_asserts.sv
// Link checker for the serial port and its peer
`timescale 1ns/100ps
module sync_serial_asserts (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic devCkOut,
	input wire logic devCkOe,
	input wire logic devDtOut,
	input wire logic devDtOe,
	input wire logic peerCkOe,
	input wire logic peerDtOe
);
	logic [4:0] riseCntReg;
	logic       ckPrevReg;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Rising clock edges seen while the port drives data
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			riseCntReg <= 5'h00;
			ckPrevReg  <= 1'b0;
		end else begin
			ckPrevReg  <= devCkOut;
			riseCntReg <= !devDtOe ? 5'h00 : riseCntReg + 5'((devCkOut && !ckPrevReg) ? 1 : 0);
		end
	end

	////////////////////////////////////////////////////////////////////////
	duplex_excl_a: assert property (!(devDtOe && peerDtOe))
		else $error("both ends drive data");
	data_on_rise_a: assert property (devDtOe && $past(devDtOe) && $changed(devDtOut) |-> $rose(devCkOut))
		else $error("data changed off a rising clock");
	frame_bits_a: assert property ($fell(devDtOe) |-> riseCntReg inside {8, 9, 16, 18})
		else $error("frame has wrong bit count");
	clock_low_a: assert property ($rose(devDtOe) |-> !devCkOut)
		else $error("frame starts with clock high");
	data_hold_a: assert property (devDtOe && $fell(devCkOut) |-> $stable(devDtOut))
		else $error("data moved at falling clock");
	clock_runs_a: assert property ($rose(devCkOut) && devDtOe |-> ##[1:256] $fell(devCkOut))
		else $error("shift clock stalled in frame");
	peer_clocked_a: assert property (peerDtOe && !peerCkOe |-> devCkOe)
		else $error("peer sends with no clock");
	slave_clock_a: assert property (peerCkOe |-> !devCkOe)
		else $error("port drives clock as slave");

	cover property ($fell(devDtOe) && riseCntReg == 16);
	cover property ($rose(peerDtOe) && devCkOe);
	cover property (peerCkOe && peerDtOe);
endmodule : sync_serial_asserts

// ===== sim/usart_sync_master_serial_test.sv
// Self-checking bench for the serial port facing its peer
`timescale 1ns/100ps
module usart_sync_master_serial_test
	import sync_serial_pkg::*;
;
	logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic [5:0]  awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        awready, wready, bvalid, arready, rvalid, irqHigh, irqLow;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        clockMaster, runClock, nineBit, txValid, txReady, rxValid;
	logic [8:0]  txData, rxData;
	logic [8:0]  rxQ[$];
	int          errCount, totalChecks;

	sync_serial_if link ();
	sync_serial_port u_sync_serial_port (.mclk(mclk), .rst_n(rst_n), .link(link), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irqHigh(irqHigh), .irqLow(irqLow));
	sync_serial_peer u_sync_serial_peer (.mclk(mclk), .rst_n(rst_n), .link(link), .clockMaster(clockMaster),
		.runClock(runClock), .nineBit(nineBit), .txData(txData), .txValid(txValid), .txReady(txReady),
		.rxData(rxData), .rxValid(rxValid));
	sync_serial_asserts u_sync_serial_asserts (.mclk(mclk), .rst_n(rst_n), .devCkOut(link.devCkOut),
		.devCkOe(link.devCkOe), .devDtOut(link.devDtOut), .devDtOe(link.devDtOe), .peerCkOe(link.peerCkOe),
		.peerDtOe(link.peerDtOe));

	always @(posedge mclk) if (rxValid) rxQ.push_back(rxData);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", w, e, g);
			errCount++;
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge mclk);
		awaddr  <= a;
		wdata   <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do @(negedge mclk); while (!(awready && wready));
		@(posedge mclk);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		bready  <= 1'b1;
		do @(negedge mclk); while (!bvalid);
		@(posedge mclk);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		araddr  <= a;
		arvalid <= 1'b1;
		do @(negedge mclk); while (!arready);
		@(posedge mclk);
		arvalid <= 1'b0;
		rready  <= 1'b1;
		do @(negedge mclk); while (!rvalid);
		d = rdata;
		r = rresp;
		@(posedge mclk);
		rready <= 1'b0;
	endtask : rd

	task automatic rdChk(input logic [5:0] a, input logic [7:0] e, input string w);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(w, {RESP_OKAY, 22'h0, e}, {r, d[29:0]});
	endtask : rdChk

	task automatic waitFlag(input int b);
		logic [31:0] d;
		logic [1:0]  r;
		d = 32'h0;
		for (int i = 0; i < 200 && !d[b]; i++)
			rd(OFF_PERIPHERAL_FLAGS, d, r);
		chk("flag wait", 32'h1, 32'(d[b]));
	endtask : waitFlag

	task automatic peerSend(input logic [8:0] v);
		@(posedge mclk);
		txData  <= v;
		txValid <= 1'b1;
		do @(negedge mclk); while (!txReady);
		@(posedge mclk);
		txValid <= 1'b0;
	endtask : peerSend

	task automatic waitPeer(input int n);
		@(posedge mclk);
		for (int i = 0; i < 2000 && rxQ.size() < n; i++)
			@(posedge mclk);
	endtask : waitPeer

	task automatic giveVerdict;
		$display("checks %0d mismatches %0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : giveVerdict

	////////////////////////////////////////////////////////////////////////
	task automatic testRegs;
		logic [31:0] d;
		logic [1:0]  r;
		rdChk(OFF_TX_STATUS_CONTROL, 8'h02, "txs reset");
		rdChk(OFF_PERIPHERAL_FLAGS, 8'h10, "flags reset");
		wr(OFF_PERIPHERAL_FLAGS, 8'h00);
		rdChk(OFF_PERIPHERAL_FLAGS, 8'h10, "flags kept");
		// Half period of seven clocks outlasts the far end's synchroniser and data turnaround
		wr(OFF_BAUD_DIVISOR, 8'h06);
		rdChk(OFF_BAUD_DIVISOR, 8'h06, "divisor");
		wstrb <= 4'hE;
		wr(OFF_BAUD_DIVISOR, 8'hFF);
		wstrb <= 4'hF;
		rdChk(OFF_BAUD_DIVISOR, 8'h06, "lane off");
		rd(6'h20, d, r);
		chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
		chk("irq idle", 32'h0, {30'h0, irqHigh, irqLow});
		$display("register test done");
	endtask : testRegs

	task automatic testTx;
		wr(OFF_RX_STATUS_CONTROL, 8'h80);
		wr(OFF_TX_STATUS_CONTROL, 8'hB0);
		wr(OFF_PERIPHERAL_ENABLES, 8'h10);
		chk("tx irq", 32'h1, {30'h0, irqHigh, irqLow});
		wr(OFF_TRANSMIT_BUFFER, 8'hA5);
		wr(OFF_TRANSMIT_BUFFER, 8'h3C);
		rdChk(OFF_PERIPHERAL_FLAGS, 8'h00, "flag held");
		waitPeer(2);
		chk("word one", 32'h0A5, 32'(rxQ[0]));
		chk("word two", 32'h03C, 32'(rxQ[1]));
		rdChk(OFF_PERIPHERAL_FLAGS, 8'h10, "flag set");
		rdChk(OFF_TX_STATUS_CONTROL, 8'hB2, "shift empty");
		nineBit <= 1'b1;
		wr(OFF_TX_STATUS_CONTROL, 8'hF1);
		wr(OFF_TRANSMIT_BUFFER, 8'h5A);
		waitPeer(3);
		chk("nine bit word", 32'h15A, 32'(rxQ[2]));
		nineBit <= 1'b0;
		wr(OFF_TX_STATUS_CONTROL, 8'h90);
		$display("transmit test done");
	endtask : testTx

	task automatic testRxSingle;
		wr(OFF_PERIPHERAL_PRIO, 8'h20);
		wr(OFF_PERIPHERAL_ENABLES, 8'h20);
		peerSend(9'h069);
		wr(OFF_RX_STATUS_CONTROL, 8'hA0);
		waitFlag(PF_RX_COMPLETE);
		chk("rx irq", 32'h2, {30'h0, irqHigh, irqLow});
		rdChk(OFF_RECEIVE_BUFFER, 8'h69, "single word");
		rdChk(OFF_RX_STATUS_CONTROL, 8'h80, "single stop");
		rdChk(OFF_PERIPHERAL_FLAGS, 8'h10, "rx flag clear");
		$display("single receive test done");
	endtask : testRxSingle

	task automatic testSlave;
		wr(OFF_TX_STATUS_CONTROL, 8'h10);
		clockMaster <= 1'b1;
		wr(OFF_RX_STATUS_CONTROL, 8'h90);
		peerSend(9'h0C3);
		waitFlag(PF_RX_COMPLETE);
		rdChk(OFF_RECEIVE_BUFFER, 8'hC3, "slave word");
		wr(OFF_RX_STATUS_CONTROL, 8'h80);
		clockMaster <= 1'b0;
		$display("slave test done");
	endtask : testSlave

	task automatic testCont;
		wr(OFF_TX_STATUS_CONTROL, 8'h90);
		peerSend(9'h012);
		wr(OFF_RX_STATUS_CONTROL, 8'hB0);
		waitFlag(PF_RX_COMPLETE);
		rdChk(OFF_RECEIVE_BUFFER, 8'h12, "cont word");
		repeat (300) @(posedge mclk);
		rdChk(OFF_RX_STATUS_CONTROL, 8'hB2, "overrun");
		wr(OFF_RX_STATUS_CONTROL, 8'h80);
		rdChk(OFF_RX_STATUS_CONTROL, 8'h80, "error cleared");
		$display("continuous test done");
	endtask : testCont

	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, clockMaster, runClock, nineBit, txValid} = '0;
		{awaddr, araddr, wdata, txData} = '0;
		wstrb = 4'hF;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		testRegs();
		testTx();
		testRxSingle();
		testSlave();
		testCont();
		giveVerdict();
	end

	initial begin
		repeat (60000) @(posedge mclk);
		errCount++;
		giveVerdict();
	end
endmodule : usart_sync_master_serial_test
